//--- bench/dual_mode_serial_eeprom_port_test.sv
// Self-checking bench for the dual-mode serial memory port
`timescale 1ns/1ps
module dual_mode_serial_eeprom_port_test;
  import eeprom_port_pkg::*;
  logic clk, rst_b, ce, sclIn, stream_mode_clock, hostLow, sdaIn, sdaOut, sdaOe, bidirMode, standby;
  logic [7:0] rd;
  logic       ak;
  int         err_total, samples_checked;

  dual_mode_serial_eeprom_port uut (.clk(clk), .rst_b(rst_b), .ce(ce), .streamModeClock(stream_mode_clock),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .bidirMode(bidirMode),
    .standby(standby));
  host_model host (.clk(clk), .sdaIn(sdaIn), .sclIn(sclIn), .streamModeClock(stream_mode_clock),
    .hostLow(hostLow));
  // Pulled-up open-drain wire
  assign sdaIn = (sdaOe ? sdaOut : 1'b1) & ~hostLow;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================================
  // Helpers
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] b);
    host.xfer(b, 1'b1, rd, ak);
    chk("ack", ak, 1'b0);
  endtask
  task automatic rdb(input logic [7:0] exp, input logic nack);
    host.xfer(8'hff, nack, rd, ak);
    chk("read data", rd, exp);
  endtask
  // Reset spans core edges and stream edges alike
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (3) host.vpulse();
    rst_b = 1'b1;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_bidir();
    chk("mode at power-up", bidirMode, 1'b0);
    ce = 1'b0;
    host.enter();
    chk("mode while frozen", bidirMode, 1'b0);
    ce = 1'b1;
    host.q();
    chk("mode after fall", bidirMode, 1'b1);
    chk("drive value", sdaOut, 1'b0);
    chk("idle at entry", standby, 1'b1);
    host.setv(1'b1);
    host.start();
    wr(8'hae);
    wr(8'h7f);
    wr(8'h3c);
    host.stop();
    host.start();
    wr(8'ha0);
    wr(8'h00);
    wr(8'h81);
    wr(8'h5a);
    host.stop();
    host.start();
    wr(8'ha0);
    wr(8'h7f);
    host.start();
    wr(8'ha1);
    rdb(8'h3c, 1'b0);
    rdb(8'h81, 1'b0);
    rdb(8'h5a, 1'b1);
    host.stop();
    chk("idle after stop", standby, 1'b1);
  endtask
  task automatic t_mismatch();
    host.start();
    host.xfer(8'h50, 1'b1, rd, ak);
    chk("foreign address ack", ak, 1'b1);
    chk("idle after mismatch", standby, 1'b1);
    host.recover();
    host.stop();
  endtask
  task automatic t_protect();
    host.setv(1'b0);
    host.start();
    wr(8'ha0);
    wr(8'h00);
    wr(8'hff);
    host.stop();
    repeat (3) host.vpulse();
    chk("stream clock in two-wire mode", sdaOe, 1'b0);
    host.setv(1'b0);
    host.start();
    wr(8'ha0);
    wr(8'h00);
    host.start();
    wr(8'ha1);
    rdb(8'h81, 1'b1);
    host.stop();
  endtask
  task automatic t_stream(input logic lvl, input logic [7:0] b0, input logic [7:0] b1);
    logic [7:0] seq [2];
    seq = '{b0, b1};
    do_reset();
    chk("mode after reset", bidirMode, 1'b0);
    repeat (2) host.vpulse();
    for (int i = 0; i < 9; i++) begin
      host.hold(i < 8 && !lvl);
      host.vpulse();
      chk("init slot", sdaOe, 1'b0);
    end
    for (int k = 0; k < 2; k++) begin
      for (int i = 7; i >= 0; i--) begin
        host.vpulse();
        chk("stream bit", sdaOe, !seq[k][i]);
      end
      host.vpulse();
      chk("ninth slot", sdaOe, 1'b0);
    end
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    err_total = 0;
    samples_checked = 0;
    ce = 1'b1;
    do_reset();
    t_bidir();
    t_mismatch();
    t_protect();
    t_stream(1'b1, 8'h3c, 8'h81);
    t_stream(1'b0, 8'h81, 8'h5a);
    finish_test();
  end
  initial begin
    #300000;
    err_total++;
    $display("unexpected watchdog: expected done, seen hang");
    finish_test();
  end
endmodule

//--- bench/eeprom_port_props.sv
// Pin-level checker for the dual-mode serial memory port
`timescale 1ns/1ps
module eeprom_port_props (
  input wire logic clk,             // Core clock
  input wire logic rst_b,           // Synchronous reset, active low
  input wire logic ce,              // Core clock enable
  input wire logic streamModeClock, // Stream clock pin
  input wire logic sclIn,           // Two-wire clock pin
  input wire logic sdaIn,           // Resolved data wire
  input wire logic sdaOut,          // Data drive value
  input wire logic sdaOe,           // Data pull-low enable
  input wire logic bidirMode,       // Two-wire mode flag
  input wire logic standby          // Slave idle flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // Pin relations
  a_open_drain: assert property (sdaOut == 1'b0)
    else $error("data pin driven high");
  a_reset_idle: assert property ($rose(rst_b) |-> !sdaOe && !bidirMode && standby)
    else $error("outputs not idle after reset");
  a_mode_cause: assert property ($rose(bidirMode) |-> !sclIn && !$past(sclIn, 2))
    else $error("mode switch without clock fall");
  a_mode_sticky: assert property (bidirMode |=> bidirMode)
    else $error("two-wire mode left");
  a_stop_idle: assert property (bidirMode && sclIn && $rose(sdaIn) |-> ##[2:6] standby)
    else $error("stop did not idle slave");
  a_start_wake: assert property (bidirMode && sclIn && $fell(sdaIn) |-> ##[2:6] !standby)
    else $error("start not detected");
  a_oe_scl_low: assert property ($past(bidirMode) && $changed(sdaOe) |-> !sclIn)
    else $error("data drive changed with clock high");
  a_idle_quiet: assert property (bidirMode && standby && $past(standby) |-> !sdaOe)
    else $error("idle slave drives data");
  c_mode: cover property ($rose(bidirMode));
  c_ack: cover property (bidirMode && $rose(sdaOe));
  c_stop: cover property (bidirMode && $rose(standby));
endmodule

bind dual_mode_serial_eeprom_port eeprom_port_props u_props (.clk(clk), .rst_b(rst_b), .ce(ce),
  .streamModeClock(streamModeClock), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .bidirMode(bidirMode), .standby(standby));

//--- bench/host_model.sv
// Display host: two-wire bus master and stream clock source
`timescale 1ns/1ps
module host_model (
  input  wire logic clk,             // Paces bus phases
  input  wire logic sdaIn,           // Resolved data wire
  output logic      sclIn,           // Two-wire clock
  output logic      streamModeClock, // Stream clock, write permit level
  output logic      hostLow          // Host pulls data low
);
  initial begin
    sclIn = 1'b1;
    streamModeClock = 1'b0;
    hostLow = 1'b0;
  end
  // ==========================================================================
  // Phases
  task automatic q(); repeat (5) @(negedge clk); endtask
  task automatic hold(input logic b); hostLow = b; endtask
  task automatic setv(input logic b); streamModeClock = b; endtask
  // Stream clock stands still between pulses so each fetch crossing can finish
  task automatic vpulse();
    @(negedge clk);
    #3 streamModeClock = 1'b1;
    #6 streamModeClock = 1'b0;
    repeat (7) @(negedge clk);
  endtask
  task automatic enter();
    sclIn = 1'b0;
    q();
  endtask
  task automatic start();
    if (!sclIn) begin
      hostLow = 1'b0;
      q();
      sclIn = 1'b1;
      q();
    end
    hostLow = 1'b1;
    q();
    sclIn = 1'b0;
    q();
  endtask
  task automatic stop();
    hostLow = 1'b1;
    q();
    sclIn = 1'b1;
    q();
    hostLow = 1'b0;
    q();
  endtask
  task automatic bitx(input logic b, output logic r);
    hostLow = ~b;
    q();
    sclIn = 1'b1;
    q();
    r = sdaIn;
    q();
    sclIn = 1'b0;
    q();
  endtask
  task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] r,
                      output logic a);
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(nine, a);
  endtask
  task automatic recover();
    logic r;
    for (int i = 0; i < 9 && !sdaIn; i++) bitx(1'b1, r);
    start();
  endtask
endmodule

//--- verilog/bit_sync.sv
// Two-flop level synchroniser, one per bit
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,     // Destination clock
  input  wire logic             ce,      // Clock enable
  input  wire logic [WIDTH-1:0] asyncIn, // Levels from another domain
  output logic      [WIDTH-1:0] syncOut  // Synchronised levels
);

  logic [WIDTH-1:0] stage1Reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (ce) begin
      stage1Reg <= asyncIn;
      syncOut   <= stage1Reg;
    end
  end

endmodule

//--- verilog/dual_mode_serial_eeprom_port.sv
// Serial port of a 128-byte display memory: stream mode and two-wire slave mode
`timescale 1ns/1ps

// Summary of operation
// - Power up in stream mode first
// - Stream one bit per rising edge, MSB first
// - Ninth stream slot releases data line
// - Stream address increments, wraps top to zero
// - No valid stream data before nine clocks
// - Init data level picks top or zero start
// - Two-wire clock fall switches mode for good
// - Bidirectional mode ignores stream clock except writes
// - Data change with clock high is start/stop
// - Data fall with clock high is start
// - Data rise with clock high is stop
// - Acknowledge each received byte low on ninth, address byte only on match
// - Address byte: fixed nibble, three ignored bits
// - Last address bit: one read, zero write
// - Ack on match; mismatch returns to standby
// - Standby at power-up and after stop
// - Stream clock low blocks all memory writes
// - 128 bytes, seven-bit word address
module dual_mode_serial_eeprom_port
  import eeprom_port_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH,
  parameter int AW    = ADDR_W,
  parameter int DW    = BYTE_W
) (
  input  wire logic clk,             // Core clock, 100 MHz
  input  wire logic rst_b,           // Synchronous reset, active low (power-up)
  input  wire logic ce,              // Clock enable for the core domain
  input  wire logic streamModeClock, // Stream clock pin, also write permit level
  input  wire logic sclIn,           // Two-wire clock pin
  input  wire logic sdaIn,           // Data pin level seen on the wire
  output logic      sdaOut,          // Data pin drive value (always low)
  output logic      sdaOe,           // Data pin pull-low enable
  output logic      bidirMode,       // High once two-wire mode is entered
  output logic      standby          // High while the slave is idle
);

  // ==========================================================================
  // Core domain synchronisers
  logic [3:0] coreSync;
  logic       sclS;
  logic       sdaS;
  logic       vclkS;
  logic       reqS;
  stream_t    s_reg;
  stream_t    s_next;

  bit_sync #(.WIDTH(4)) u_core_sync (
    .clk     (clk),
    .ce      (ce),
    .asyncIn ({s_reg.reqToggle, streamModeClock, sdaIn, sclIn}),
    .syncOut (coreSync)
  );

  assign sclS  = coreSync[0];
  assign sdaS  = coreSync[1];
  assign vclkS = coreSync[2];
  assign reqS  = coreSync[3];

  // ==========================================================================
  // Storage
  core_t             c_reg;
  core_t             c_next;
  logic              memWrEn;
  logic [AW-1:0]     memWrAddr;
  logic [DW-1:0]     rdA;
  logic [DW-1:0]     rdB;

  eeprom_array #(.DEPTH(DEPTH), .AW(AW), .DW(DW)) u_array (
    .clk     (clk),
    .ce      (ce),
    .wrEn    (memWrEn),
    .wrAddr  (memWrAddr),
    .wrData  (c_reg.shift),
    .rdAddrA (c_reg.ptr),
    .rdDataA (rdA),
    .rdAddrB (s_reg.addr),
    .rdDataB (rdB)
  );

  // ==========================================================================
  // Two-wire line events
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  assign sclRise   = sclS & ~c_reg.sclPrev;
  assign sclFall   = ~sclS & c_reg.sclPrev;
  assign startCond = sclS & c_reg.sclPrev & c_reg.sdaPrev & ~sdaS;
  assign stopCond  = sclS & c_reg.sclPrev & ~c_reg.sdaPrev & sdaS;

  // ==========================================================================
  // Core counter and address decode
  logic byteDone;
  logic addrMatch;

  assign byteDone  = (c_reg.cnt == CNT_NINTH);
  // Bits 3..1 of the address byte are not compared
  assign addrMatch = (c_reg.shift[DW-1:DEV_NIB_LSB] == DEV_NIBBLE);

  // ==========================================================================
  // Core domain next state
  logic loadByte;

  always_comb begin
    c_next    = c_reg;
    memWrEn   = 1'b0;
    memWrAddr = c_reg.ptr;
    loadByte  = 1'b0;

    c_next.sclPrev = sclS;
    c_next.sdaPrev = sdaS;

    // Stream fetch: the address word is stable long before its toggle arrives
    if (reqS != c_reg.reqSeen) begin
      c_next.reqSeen    = reqS;
      c_next.fetched    = rdB;
      c_next.fetchValid = 1'b1;
    end

    // Only power-up reset clears this flag
    if (!c_reg.bidir && sclFall) begin
      c_next.bidir = 1'b1;
    end

    if (c_reg.bidir) begin
      if (startCond) begin
        c_next.st       = ST_RECV;
        c_next.ph       = PH_DEV;
        c_next.cnt      = CNT_ZERO;
        c_next.driveLow = 1'b0;
      end else if (stopCond) begin
        c_next.st       = ST_STANDBY;
        c_next.driveLow = 1'b0;
      end else begin
        case (c_reg.st)
          ST_RECV: begin
            if (sclRise && !byteDone) begin
              c_next.shift = {c_reg.shift[DW-2:0], sdaS};
              c_next.cnt   = c_reg.cnt + CNT_ONE;
            end else if (sclFall && byteDone) begin
              case (c_reg.ph)
                PH_DEV: begin
                  if (addrMatch) begin
                    c_next.rw       = c_reg.shift[RW_BIT];
                    c_next.driveLow = 1'b1;
                    c_next.st       = ST_ACK;
                  end else begin
                    c_next.st = ST_STANDBY;
                  end
                end
                PH_WORD: begin
                  c_next.ptr      = c_reg.shift[AW-1:0];
                  c_next.driveLow = 1'b1;
                  c_next.st       = ST_ACK;
                end
                default: begin
                  // Writes need the stream clock pin held high
                  memWrEn = vclkS;
                  c_next.ptr[PAGE_BITS-1:0] = c_reg.ptr[PAGE_BITS-1:0] +
                                              {{(PAGE_BITS-1){1'b0}}, 1'b1};
                  c_next.driveLow = 1'b1;
                  c_next.st       = ST_ACK;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (sclFall) begin
              c_next.driveLow = 1'b0;
              if (c_reg.ph == PH_DEV && c_reg.rw) begin
                loadByte = 1'b1;
              end else begin
                c_next.st  = ST_RECV;
                c_next.cnt = CNT_ZERO;
                c_next.ph  = (c_reg.ph == PH_DEV) ? PH_WORD : PH_DATA;
              end
            end
          end
          ST_SEND: begin
            if (sclFall) begin
              if (byteDone) begin
                c_next.driveLow = 1'b0;
                c_next.ackSeen  = 1'b0;
                c_next.st       = ST_MACK;
              end else begin
                c_next.driveLow = ~c_reg.shift[DW-1];
                c_next.shift    = {c_reg.shift[DW-2:0], 1'b0};
                c_next.cnt      = c_reg.cnt + CNT_ONE;
              end
            end
          end
          ST_MACK: begin
            if (sclRise) begin
              c_next.ackSeen = ~sdaS;
            end else if (sclFall) begin
              if (c_reg.ackSeen) begin
                loadByte = 1'b1;
              end else begin
                c_next.st = ST_STANDBY;
              end
            end
          end
          default: begin
            c_next.driveLow = 1'b0;
          end
        endcase
      end
    end

    // Read pointer rolls over the whole array
    if (loadByte) begin
      c_next.driveLow = ~rdA[DW-1];
      c_next.shift    = {rdA[DW-2:0], 1'b0};
      c_next.cnt      = CNT_ONE;
      c_next.ptr      = c_reg.ptr + {{(AW-1){1'b0}}, 1'b1};
      c_next.st       = ST_SEND;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      c_reg.bidir      <= 1'b0;
      c_reg.st         <= ST_STANDBY;
      c_reg.ph         <= PH_DEV;
      c_reg.cnt        <= CNT_ZERO;
      c_reg.shift      <= '0;
      c_reg.rw         <= 1'b0;
      c_reg.ackSeen    <= 1'b0;
      c_reg.driveLow   <= 1'b0;
      c_reg.ptr        <= PTR_RESET;
      c_reg.sclPrev    <= 1'b1;
      c_reg.sdaPrev    <= 1'b1;
      c_reg.reqSeen    <= 1'b0;
      c_reg.fetchValid <= 1'b0;
      c_reg.fetched    <= '0;
    end else if (ce) begin
      c_reg <= c_next;
    end
  end

  // ==========================================================================
  // Stream domain, clocked by the stream clock pin
  // Reset, enable and the data level each pass two stream-clock flops
  logic [2:0] streamSync;
  logic       streamRst_b;
  logic       streamSdaS;
  logic       streamCeS;

  bit_sync #(.WIDTH(3)) u_stream_sync (
    .clk     (streamModeClock),
    .ce      (1'b1),
    .asyncIn ({ce, rst_b, sdaIn}),
    .syncOut (streamSync)
  );

  assign streamSdaS  = streamSync[0];
  assign streamRst_b = streamSync[1];
  assign streamCeS   = streamSync[2];

  // ==========================================================================
  // Stream counter decode
  logic initDone;
  logic firstBit;
  logic ninthSlot;

  assign initDone  = (s_reg.cnt == INIT_LAST);
  assign firstBit  = (s_reg.cnt == CNT_ZERO);
  assign ninthSlot = (s_reg.cnt == CNT_NINTH);

  // The clock may stop between bursts, so nothing here waits on later edges
  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      SM_INIT: begin
        s_next.driveLow = 1'b0;
        if (initDone) begin
          s_next.st        = SM_RUN;
          s_next.cnt       = CNT_ZERO;
          s_next.addr      = streamSdaS ? STREAM_TOP : STREAM_BOTTOM;
          s_next.reqToggle = ~s_reg.reqToggle;
        end else begin
          s_next.cnt = s_reg.cnt + CNT_ONE;
        end
      end
      SM_RUN: begin
        if (firstBit) begin
          // Fetched word was requested a whole ninth slot earlier
          s_next.driveLow = ~c_reg.fetched[DW-1];
          s_next.shift    = {c_reg.fetched[DW-2:0], 1'b0};
          s_next.cnt      = CNT_ONE;
        end else if (!ninthSlot) begin
          s_next.driveLow = ~s_reg.shift[DW-1];
          s_next.shift    = {s_reg.shift[DW-2:0], 1'b0};
          s_next.cnt      = s_reg.cnt + CNT_ONE;
        end else begin
          s_next.driveLow  = 1'b0;
          s_next.addr      = s_reg.addr + {{(AW-1){1'b0}}, 1'b1};
          s_next.reqToggle = ~s_reg.reqToggle;
          s_next.cnt       = CNT_ZERO;
        end
      end
      default: begin
        s_next.st = SM_INIT;
      end
    endcase
  end

  // A frozen core also freezes the stream side, so no fetch request is lost
  always_ff @(posedge streamModeClock) begin
    if (!streamRst_b) begin
      s_reg.st        <= SM_INIT;
      s_reg.cnt       <= CNT_ZERO;
      s_reg.addr      <= STREAM_BOTTOM;
      s_reg.shift     <= '0;
      s_reg.driveLow  <= 1'b0;
      s_reg.reqToggle <= 1'b0;
    end else if (streamCeS) begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Pin drive: stream output is masked until its first fetch has landed
  // Open drain: the pin is only ever pulled low, never driven high
  assign sdaOut    = 1'b0;
  assign sdaOe     = c_reg.bidir ? c_reg.driveLow
                                 : (s_reg.driveLow & c_reg.fetchValid);
  assign bidirMode = c_reg.bidir;
  assign standby   = (c_reg.st == ST_STANDBY);

endmodule

//--- verilog/eeprom_array.sv
// Flip-flop storage array with one write port and two read ports
`timescale 1ns/1ps
module eeprom_array #(
  parameter int DEPTH = 128,
  parameter int AW    = 7,
  parameter int DW    = 8
) (
  input  wire logic          clk,     // Core clock
  input  wire logic          ce,      // Clock enable
  input  wire logic          wrEn,    // Write strobe
  input  wire logic [AW-1:0] wrAddr,  // Write index
  input  wire logic [DW-1:0] wrData,  // Write data
  input  wire logic [AW-1:0] rdAddrA, // Read index, two-wire side
  output logic      [DW-1:0] rdDataA, // Read data, two-wire side
  input  wire logic [AW-1:0] rdAddrB, // Read index, stream side
  output logic      [DW-1:0] rdDataB  // Read data, stream side
);

  // Contents are nonvolatile in spirit, so reset leaves them alone
  logic [DW-1:0] memReg [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && wrEn) begin
      memReg[wrAddr] <= wrData;
    end
  end

  assign rdDataA = memReg[rdAddrA];
  assign rdDataB = memReg[rdAddrB];

endmodule

//--- verilog/eeprom_port_pkg.sv
// Shared constants and types for the dual-mode serial memory port
package eeprom_port_pkg;

  // ==========================================================================
  // Sizes
  localparam int BYTE_W    = 8;
  localparam int ADDR_W    = 7;
  localparam int MEM_DEPTH = 128;
  localparam int PAGE_BITS = 3;

  // ==========================================================================
  // Address byte layout and stream addresses
  localparam logic [3:0]        DEV_NIBBLE    = 4'ha;
  localparam int                DEV_NIB_LSB   = 4;
  localparam int                RW_BIT        = 0;
  localparam logic [ADDR_W-1:0] STREAM_TOP    = 7'h7f;
  localparam logic [ADDR_W-1:0] STREAM_BOTTOM = 7'h00;
  localparam logic [ADDR_W-1:0] PTR_RESET     = 7'h00;

  // ==========================================================================
  // Bit counters: eight data slots then a ninth slot
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [3:0] CNT_ONE   = 4'h1;
  localparam logic [3:0] CNT_NINTH = 4'h8;
  localparam logic [3:0] INIT_LAST = 4'h8;

  // ==========================================================================
  // State types
  typedef enum logic [2:0] {ST_STANDBY, ST_RECV, ST_ACK, ST_SEND, ST_MACK} slave_state_t;
  typedef enum logic [1:0] {PH_DEV, PH_WORD, PH_DATA} phase_t;
  typedef enum logic       {SM_INIT, SM_RUN} stream_state_t;

  typedef struct packed {
    logic               bidir;
    slave_state_t       st;
    phase_t             ph;
    logic [3:0]         cnt;
    logic [BYTE_W-1:0]  shift;
    logic               rw;
    logic               ackSeen;
    logic               driveLow;
    logic [ADDR_W-1:0]  ptr;
    logic               sclPrev;
    logic               sdaPrev;
    logic               reqSeen;
    logic               fetchValid;
    logic [BYTE_W-1:0]  fetched;
  } core_t;

  typedef struct packed {
    stream_state_t      st;
    logic [3:0]         cnt;
    logic [ADDR_W-1:0]  addr;
    logic [BYTE_W-1:0]  shift;
    logic               driveLow;
    logic               reqToggle;
  } stream_t;

endpackage
